// [logic/psk_pkg.sv]
// Shared constants and carriers for the subscriber-side session key controller
`default_nettype none

package psk_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int ENT_N = 4;
  localparam int EW = 2;
  localparam int KEY_W = 128;
  localparam int LLID_W = 16;
  localparam int SEQ_W = 64;
  localparam int CH_W = 8;
  localparam int IV_PAD_W = KEY_W - SEQ_W - LLID_W - CH_W;
  localparam int ADDR_W = 4;
  localparam int KWORDS = 4;

  // ----------------------------------------
  // Register word addresses
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_KEY0 = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CMD = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h9;
  localparam logic [ADDR_W-1:0] REG_MCAST = 4'ha;
  localparam logic [ADDR_W-1:0] REG_ACK = 4'hb;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_FVAL_BIT = 1;
  localparam int CMD_ENT_LSB = 0;
  localparam int CMD_HOLD_BIT = 4;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [ENT_N-1:0] MCAST_RST = 4'h0;
  localparam logic [1:0] ACK_MAX = 2'h1;

  // ----------------------------------------
  // Header carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic cipher_on_flag;
    logic key_slot_field;
    logic [LLID_W-1:0] llid;
    logic [CH_W-1:0] ch;
    logic [SEQ_W-1:0] seq;
  } psk_rx_hdr_t;

  typedef struct packed {
    logic valid;
    logic cipher_on_flag;
    logic key_slot_field;
    logic [LLID_W-1:0] llid;
    logic [KEY_W-1:0] key;
  } psk_tx_hdr_t;

endpackage

`default_nettype wire

// [logic/psk_key_ctrl.sv]
// Subscriber-side session key store, activation and header signalling
// ----------------------------------------
// ----------------------------------------
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module psk_key_ctrl
  import psk_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire psk_rx_hdr_t i_rx_hdr,
  output logic o_rx_valid,
  output logic [KEY_W-1:0] o_rx_key,
  output logic [KEY_W-1:0] o_rx_iv,
  input wire logic i_tx_req,
  input wire logic [LLID_W-1:0] i_tx_llid,
  output psk_tx_hdr_t o_tx_hdr,
  output logic o_ack_valid,
  output logic o_ack_ok,
  output logic [1:0] o_ack_cnt
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Two keys per entity, index {entity, slot}
  logic [KEY_W-1:0] key_mem [ENT_N*2];
  logic [KEY_W-1:0] kbuf_reg;
  logic [KWORDS-1:0] kseen_reg;
  logic [ENT_N-1:0] cur_slot_reg;
  logic [ENT_N-1:0] tx_slot_reg;
  logic [ENT_N-1:0] tx_pend_reg;
  logic [ENT_N-1:0] rx_enc_reg;
  logic [ENT_N-1:0] mcast_reg;
  logic [1:0] ctrl_reg;
  logic [1:0] acc_cnt_reg;
  logic acc_ok_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic cmd;
  logic cmd_ok;
  logic cmd_final;
  logic [EW-1:0] cmd_ent;
  logic [EW-1:0] rx_ent;
  logic [EW-1:0] tx_ent;
  logic rx_switch;
  logic tx_on;
  logic tx_slot;

  // Command strobe and its fields
  assign cmd = i_wr && (i_addr == REG_CMD);
  assign cmd_ent = i_wdata[CMD_ENT_LSB +: EW];
  // A key is usable only once all four of its words came in
  assign cmd_ok = &kseen_reg;
  // At most two installs share one response, as for paired key actions
  assign cmd_final = !i_wdata[CMD_HOLD_BIT] || (acc_cnt_reg == ACK_MAX);

  // Entity is taken from the low LLID bits
  assign rx_ent = i_rx_hdr.llid[EW-1:0];
  assign tx_ent = i_tx_llid[EW-1:0];

  // Received index differs from the active one
  assign rx_switch = i_rx_hdr.valid && i_rx_hdr.cipher_on_flag
    && (i_rx_hdr.key_slot_field != cur_slot_reg[rx_ent]);

  // Group keys are never used upstream
  assign tx_on = !mcast_reg[tx_ent] && (ctrl_reg[CTRL_FORCE_BIT]
    ? ctrl_reg[CTRL_FVAL_BIT] : rx_enc_reg[tx_ent]);
  // Pending toggle lands on the very next upstream header only
  assign tx_slot = tx_slot_reg[tx_ent] ^ tx_pend_reg[tx_ent];

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Control and group-membership mask
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_reg <= CTRL_RST;
      mcast_reg <= MCAST_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == REG_CTRL)
        ctrl_reg <= i_wdata[1:0];
      if (i_addr == REG_MCAST)
        mcast_reg <= i_wdata[ENT_N-1:0];
    end
  end

  // Key words staged before an install command
  genvar gw;
  generate
    for (gw = 0; gw < KWORDS; gw++)
    begin : g_kword
      always_ff @(posedge i_ref_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          kbuf_reg[gw*32 +: 32] <= 32'h0;
          kseen_reg[gw] <= 1'b0;
        end
        else if (i_wr && (i_addr == REG_KEY0 + ADDR_W'(gw)))
        begin
          kbuf_reg[gw*32 +: 32] <= i_wdata;
          kseen_reg[gw] <= 1'b1;
        end
        else if (cmd)
          kseen_reg[gw] <= 1'b0;
      end
    end
  endgenerate

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= 32'h0;
    else if (i_rd)
    begin
      case (i_addr)
        REG_CTRL: o_rdata <= {30'h0, ctrl_reg};
        REG_STAT: o_rdata <= {16'h0, rx_enc_reg, tx_pend_reg,
                              tx_slot_reg, cur_slot_reg};
        REG_MCAST: o_rdata <= {28'h0, mcast_reg};
        REG_ACK: o_rdata <= {25'h0, acc_ok_reg, acc_cnt_reg, kseen_reg};
        default: o_rdata <= 32'h0;
      endcase
    end
    else
      o_rdata <= 32'h0;
  end

  // ----------------------------------------
  // Key install
  // ----------------------------------------
  // Fresh key lands beside the key in use; no reset on the array.
  // Installing while a switch lands the same cycle hits the newly active slot.
  // One command installs for one entity only; there is no group-wide write
  always_ff @(posedge i_ref_clk)
  begin
    if (cmd && cmd_ok)
      key_mem[{cmd_ent, ~cur_slot_reg[cmd_ent]}] <= kbuf_reg;
  end

  // Each install is answered; held installs share one reply
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      acc_cnt_reg <= 2'h0;
      acc_ok_reg <= 1'b1;
      o_ack_valid <= 1'b0;
      o_ack_ok <= 1'b0;
      o_ack_cnt <= 2'h0;
    end
    else
    begin
      o_ack_valid <= 1'b0;
      if (cmd && cmd_final)
      begin
        o_ack_valid <= 1'b1;
        o_ack_ok <= acc_ok_reg && cmd_ok;
        o_ack_cnt <= acc_cnt_reg + 2'h1;
        acc_cnt_reg <= 2'h0;
        acc_ok_reg <= 1'b1;
      end
      else if (cmd)
      begin
        acc_cnt_reg <= acc_cnt_reg + 2'h1;
        acc_ok_reg <= acc_ok_reg && cmd_ok;
      end
    end
  end

  // ----------------------------------------
  // Decryption key activation
  // ----------------------------------------
  // Runs on every header, apart from the upstream process
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cur_slot_reg <= '0;
      rx_enc_reg <= '0;
    end
    else if (i_rx_hdr.valid)
    begin
      rx_enc_reg[rx_ent] <= i_rx_hdr.cipher_on_flag;
      if (rx_switch)
        cur_slot_reg[rx_ent] <= ~cur_slot_reg[rx_ent];
    end
  end

  // Key and counter handed to the channel decryptor
  // Header index picks the key; the active index merely follows it
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_rx_valid <= 1'b0;
      o_rx_key <= '0;
      o_rx_iv <= '0;
    end
    else
    begin
      o_rx_valid <= i_rx_hdr.valid;
      if (i_rx_hdr.valid)
      begin
        o_rx_key <= key_mem[{rx_ent, i_rx_hdr.key_slot_field}];
        o_rx_iv <= {i_rx_hdr.seq, i_rx_hdr.llid, i_rx_hdr.ch,
                    {IV_PAD_W{1'b0}}};
      end
    end
  end

  // ----------------------------------------
  // Encryption key activation
  // ----------------------------------------
  // Pending toggle per entity; a set beats a same-cycle clear
  genvar ge;
  generate
    for (ge = 0; ge < ENT_N; ge++)
    begin : g_pend
      always_ff @(posedge i_ref_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          tx_pend_reg[ge] <= 1'b0;
        else if (rx_switch && rx_ent == EW'(ge) && !mcast_reg[ge])
          tx_pend_reg[ge] <= 1'b1;
        else if (i_tx_req && tx_ent == EW'(ge))
          tx_pend_reg[ge] <= 1'b0;
      end
    end
  endgenerate

  // Next upstream header carries the toggled index
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      tx_slot_reg <= '0;
    else if (i_tx_req)
      tx_slot_reg[tx_ent] <= tx_slot;
  end

  // Upstream header fields and the key for its payload
  // Group entities never carry a key upstream, whatever the force bit says
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_tx_hdr <= '0;
    else
    begin
      o_tx_hdr.valid <= i_tx_req;
      if (i_tx_req)
      begin
        o_tx_hdr.cipher_on_flag <= tx_on;
        o_tx_hdr.key_slot_field <= tx_slot;
        o_tx_hdr.llid <= i_tx_llid;
        o_tx_hdr.key <= tx_on ? key_mem[{tx_ent, tx_slot}] : '0;
      end
    end
  end

endmodule // psk_key_ctrl

`default_nettype wire

// [dv/psk_kc_props.sv]
// Port checker for the subscriber-side key controller
`timescale 1ns/100ps
`default_nettype none
module psk_kc_props
  import psk_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire psk_rx_hdr_t i_rx_hdr,
  input wire logic o_rx_valid,
  input wire logic [KEY_W-1:0] o_rx_iv,
  input wire logic i_tx_req,
  input wire logic [LLID_W-1:0] i_tx_llid,
  input wire psk_tx_hdr_t o_tx_hdr,
  input wire logic o_ack_valid,
  input wire logic [1:0] o_ack_cnt
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // Request steps
  sequence s_rx; i_rx_hdr.valid; endsequence
  sequence s_tx; i_tx_req; endsequence
  AST_RX: assert property (s_rx |=> o_rx_valid)
    else $error("rx header not answered");
  AST_RX_Q: assert property (!i_rx_hdr.valid |=> !o_rx_valid)
    else $error("rx answer without header");
  AST_IV: assert property (s_rx |=> o_rx_iv ==
    {$past(i_rx_hdr.seq), $past(i_rx_hdr.llid), $past(i_rx_hdr.ch), 40'h0})
    else $error("rx counter wrong");
  AST_TX: assert property (s_tx |=> o_tx_hdr.valid
    && o_tx_hdr.llid == $past(i_tx_llid)) else $error("tx header lost");
  AST_TX_Q: assert property (!i_tx_req |=> !o_tx_hdr.valid)
    else $error("tx header without request");
  AST_HOLD: assert property (!i_tx_req |=> $stable(o_tx_hdr.key_slot_field))
    else $error("tx slot moved between headers");
  AST_OFF: assert property (o_tx_hdr.valid && !o_tx_hdr.cipher_on_flag
    |-> o_tx_hdr.key == '0) else $error("key shown with cipher off");
  AST_CNT: assert property (o_ack_valid |-> o_ack_cnt inside {2'h1, 2'h2})
    else $error("ack count out of range");
endmodule // psk_kc_props
bind psk_key_ctrl psk_kc_props psk_kc_props_i (.i_ref_clk, .i_rstn, .i_rx_hdr,
  .o_rx_valid, .o_rx_iv, .i_tx_req, .i_tx_llid, .o_tx_hdr, .o_ack_valid, .o_ack_cnt);
`default_nettype wire

// [dv/psk_head_model.sv]
// Behavioural head-end sending envelope headers
`timescale 1ns/100ps
`default_nettype none
module psk_head_model
  import psk_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_expire,
  input wire logic i_send,
  input wire logic [LLID_W-1:0] i_llid,
  input wire logic [SEQ_W-1:0] i_seq,
  output psk_rx_hdr_t o_hdr
);
  logic [ENT_N-1:0] armed_reg;
  logic [ENT_N-1:0] slot_reg;
  logic [EW-1:0] ent;
  logic nxt;
  assign ent = i_llid[EW-1:0];
  assign nxt = slot_reg[ent] ^ armed_reg[ent];
  // Expiry arms a switch that the next header of the entity carries
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      armed_reg <= '0;
      slot_reg <= '0;
      o_hdr <= '0;
    end
    else if (i_send)
    begin
      armed_reg[ent] <= 1'b0;
      slot_reg[ent] <= nxt;
      o_hdr <= '{1'b1, 1'b1, nxt, i_llid, i_seq[CH_W-1:0], i_seq};
    end
    else
    begin
      armed_reg[ent] <= armed_reg[ent] | i_expire;
      o_hdr <= {1'b0, ~o_hdr[$bits(o_hdr)-2:0]}; // Idle fields flip every cycle
    end
  end
endmodule // psk_head_model
`default_nettype wire

// [dv/psk_key_ctrl_tb_top.sv]
// Self-checking bench for the subscriber-side key controller
`timescale 1ns/100ps
`default_nettype none
`define CMP(g, e) chk(g, e)
module psk_key_ctrl_tb_top
  import psk_pkg::*;
;
  logic clk, rstn, wr, rd, txq, xq, snd, rxv, ackv, acko;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [LLID_W-1:0] llid, txll;
  logic [SEQ_W-1:0] seq;
  logic [1:0] ackc;
  logic [KEY_W-1:0] rxk, rxiv, mkey [ENT_N][2];
  logic [ENT_N-1:0] mmask = 4'h8;
  psk_rx_hdr_t rxh;
  psk_tx_hdr_t txh;
  bit mcur [ENT_N], mtx [ENT_N], mpend [ENT_N];
  bit [1:0] mctrl;
  logic [31:0] st;
  int n_mismatch, checks_done;
  logic [31:0] rng = 32'h0001_1cdb; // Seed 72923
  psk_key_ctrl psk_key_ctrl_i (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_hdr(rxh),
    .o_rx_valid(rxv), .o_rx_key(rxk), .o_rx_iv(rxiv), .i_tx_req(txq), .i_tx_llid(txll),
    .o_tx_hdr(txh), .o_ack_valid(ackv), .o_ack_ok(acko), .o_ack_cnt(ackc));
  psk_head_model psk_head_model_i (.i_ref_clk(clk), .i_rstn(rstn), .i_expire(xq),
    .i_send(snd), .i_llid(llid), .i_seq(seq), .o_hdr(rxh));
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic chk(input logic [KEY_W-1:0] g, input logic [KEY_W-1:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One-cycle strobes, read data taken in the following cycle
  task automatic bus(input bit w, input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Key words then command; reference store follows the inactive slot
  task automatic install(input int e, input bit h, input bit full);
    logic [KEY_W-1:0] k;
    k = {xs(), xs(), xs(), xs()};
    for (int i = 0; i < KWORDS * full; i++)
      bus(1, ADDR_W'(REG_KEY0 + i), k[32*i +: 32]);
    bus(1, REG_CMD, {27'h0, h, 2'h0, 2'(e)});
    if (full) mkey[e][!mcur[e]] = k;
    `CMP(ackv, !h);
    if (!h) `CMP(acko, full);
  endtask
  // Header from the head-end, optionally after a timer expiry
  task automatic rx(input int e, input bit x);
    logic [SEQ_W-1:0] s;
    bit sl;
    s = {xs(), xs()};
    sl = mcur[e] ^ x;
    @(posedge clk);
    llid <= {14'h0a0, 2'(e)};
    seq <= s;
    xq <= x;
    @(posedge clk);
    xq <= 1'b0;
    snd <= 1'b1;
    @(posedge clk);
    snd <= 1'b0;
    @(posedge clk);
    #1;
    if (x && !mmask[e]) mpend[e] = 1;
    mcur[e] = sl;
    `CMP(rxv, 1'b1);
    `CMP(rxk, mkey[e][sl]);
    `CMP(rxiv, {s, 14'h0a0, 2'(e), s[7:0], 40'h0});
  endtask
  // Upstream header request
  task automatic tx(input int e);
    bit on;
    on = !mmask[e] && (mctrl[0] ? mctrl[1] : 1'b1);
    @(posedge clk);
    txll <= {14'h0b0, 2'(e)};
    txq <= 1'b1;
    @(posedge clk);
    txq <= 1'b0;
    #1;
    if (mpend[e]) mtx[e] = !mtx[e];
    mpend[e] = 0;
    `CMP(txh.cipher_on_flag, on);
    `CMP(txh.key, on ? mkey[e][mtx[e]] : '0);
    if (!mmask[e]) `CMP(txh.key_slot_field, mtx[e]);
  endtask
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    {rstn, wr, rd, txq, xq, snd, addr, wdata, llid, txll, seq} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    bus(0, REG_STAT, 0);
    `CMP(d, 32'h0);
    bus(1, REG_MCAST, 32'(mmask));
    bus(0, REG_MCAST, 0);
    `CMP(d, 32'(mmask));
    bus(0, 4'h3, 0);
    `CMP(d, 32'h0);
    for (int e = 0; e < ENT_N; e++)
    begin
      install(e, 0, 1); // Delivered before the switch
      rx(e, 1);
      tx(e);
      tx(e);
      install(e, 0, 1);
      rx(e, 0);
      rx(e, 1);
      tx(e);
    end
    install(1, 0, 0);
    `CMP(ackc, 2'h1);
    install(1, 0, 1); // Retry after a NACK
    rx(1, 1); // Retried key still activates
    install(0, 1, 1);
    install(0, 0, 1);
    `CMP(ackc, 2'h2);
    mctrl = 2'h1;
    bus(1, REG_CTRL, 32'(mctrl));
    bus(0, REG_CTRL, 0);
    `CMP(d, 32'(mctrl));
    tx(1); // Forced off while downstream is encrypted
    mctrl = 2'h3;
    bus(1, REG_CTRL, 32'(mctrl));
    tx(3); // Forcing on never sends a group key upstream
    st = 32'h0000_f000;
    for (int e = 0; e < ENT_N; e++)
      st |= (32'(mcur[e]) << e) | (32'(mtx[e]) << (4 + e)) | (32'(mpend[e]) << (8 + e));
    bus(0, REG_STAT, 0);
    `CMP(d, st);
    bus(1, REG_KEY0, xs());
    bus(0, REG_ACK, 0);
    `CMP(d, 32'h0000_0041);
    test_done();
  end
endmodule // psk_key_ctrl_tb_top
`default_nettype wire
